// file: hdl/wdrcu_top.sv
// Watchdog timer with control register and reset-cause register
`timescale 1ns/1ps

// What this block does
// - Reset enable stays forced high while the watchdog reset cause is set.
// - Clearing reset enable or changing prescale needs the change window open.
// - Change window bit clears itself four system clocks after it is set.
// - Mode decoded from reset enable and interrupt enable bits.
// - Interrupt flag sets on double time-out when interrupt action configured.
// - Interrupt flag clears on vector taken or on software write of one.
// - Interrupt request only with core enable, interrupt enable and pending flag.
// - Combined mode: vector taken clears interrupt enable and flag.
// - Combined mode: unserviced flag at next time-out gives a system reset.
// - Prescale field is bit 5 and bits 2 to 0; selects time-out.
// - USB, watchdog, brown-out, external flags; cleared by power-on or write zero.
// - Power-on flag set by power-on, cleared only by software writing zero.
// - Reset-cause bits 7 to 6 and 4 read as zero.
// - Always-on fuse forces reset mode, enable locked one, irq locked zero.
// - Counter advances on ticks at a 128 kHz oscillator rate divided down from the system clock.
// - Action happens at twice the selected time-out since last restart.
module wdrcu_top
	import wdrcu_pkg::*;
#(
	parameter int unsigned BASE_TIMEOUT = WDRCU_BASE_TIMEOUT,
	parameter int unsigned DIV_CYCLES = WDRCU_DIV_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WDRCU_ADDR_W-1:0] reg_addr,
	input wire logic [WDRCU_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [WDRCU_DATA_W-1:0] reg_rdata,
	input wire logic wd_always_on_fuse,
	input wire logic core_global_irq_enable,
	input wire logic wd_restart,
	input wire logic wd_irq_ack,
	output logic wd_irq_req,
	output logic wd_system_reset,
	input wire logic external_reset_event,
	input wire logic brownout_event,
	input wire logic usb_reset_event
);

	wdrcu_state_type s;
	wdrcu_state_type next_s;

	wdrcu_mode_type wd_mode;
	logic ctl_wr;
	logic cause_wr;
	logic open_wr;
	logic tick;
	logic expire;
	logic set_irq;
	logic fire_rst;
	logic irq_taken;
	logic any_sysrst;
	logic [3:0] pre_eff;
	logic [4:0] shift_amt;
	logic [WDRCU_CNT_W-1:0] limit;
	logic [WDRCU_CNT_W-1:0] div_last;

	// Register decode
	assign ctl_wr = reg_wr && (reg_addr == WDRCU_CTL_OFFSET);
	assign cause_wr = reg_wr && (reg_addr == WDRCU_CAUSE_OFFSET);
	assign open_wr = ctl_wr && reg_wdata[WDRCU_WIN_BIT]
		&& reg_wdata[WDRCU_RST_EN_BIT];

	// Mode straight from the two enable bits
	assign wd_mode = wdrcu_mode_type'({s.rst_enable, s.irq_enable});

	// Slow oscillator tick as an enable pulse
	assign div_last = WDRCU_CNT_W'(DIV_CYCLES - 1);
	assign tick = (WDRCU_CNT_W'(s.div_cnt) == div_last);

	// Reserved prescale codes behave as the longest period
	assign pre_eff = (s.prescale > WDRCU_PRE_MAX_CODE) ?
		WDRCU_PRE_MAX_CODE : s.prescale;
	assign shift_amt = {1'h0, pre_eff} + 5'h1;

	// Double time-out limit in oscillator ticks
	assign limit = WDRCU_CNT_W'(BASE_TIMEOUT) << shift_amt;

	// Expiry on the tick that completes twice the period
	assign expire = tick && (s.cnt == limit - WDRCU_CNT_W'(1))
		&& (wd_mode != WDRCU_MODE_STOPPED);

	// Interrupt request and acceptance
	assign wd_irq_req = core_global_irq_enable && s.irq_enable
		&& s.irq_flag;
	assign irq_taken = wd_irq_ack && wd_irq_req;

	// Any cause that resets the system reloads the control register
	assign any_sysrst = fire_rst || external_reset_event
		|| brownout_event || usb_reset_event;

	// Action on expiry per mode
	always_comb
	begin
		set_irq = 1'b0;
		fire_rst = 1'b0;
		case (wd_mode)
			WDRCU_MODE_STOPPED:
			begin
				set_irq = 1'b0;
			end
			WDRCU_MODE_IRQ:
			begin
				set_irq = expire;
			end
			WDRCU_MODE_RESET:
			begin
				fire_rst = expire;
			end
			WDRCU_MODE_IRQ_RESET:
			begin
				// Pending flag not serviced in time escalates to reset
				set_irq = expire && !s.irq_flag;
				fire_rst = expire && s.irq_flag;
			end
			default:
			begin
				set_irq = 1'b0;
			end
		endcase
	end

	// Next-state logic of the whole unit
	always_comb
	begin
		next_s = s;
		next_s.rst_pulse = fire_rst;

		// Divider and counter; restart or stop clears both
		if (wd_restart || wd_mode == WDRCU_MODE_STOPPED)
		begin
			next_s.div_cnt = '0;
			next_s.cnt = '0;
		end
		else if (tick)
		begin
			next_s.div_cnt = '0;
			next_s.cnt = expire ? '0 : s.cnt + WDRCU_CNT_W'(1);
		end
		else
		begin
			next_s.div_cnt = s.div_cnt + WDRCU_DIV_W'(1);
		end

		// Change window runs down and closes by itself
		if (s.win)
		begin
			if (s.win_cnt == '0)
			begin
				next_s.win = 1'b0;
			end
			else
			begin
				next_s.win_cnt = s.win_cnt - WDRCU_WIN_W'(1);
			end
		end

		// Software write to the control register
		if (ctl_wr)
		begin
			if (reg_wdata[WDRCU_IRQ_FLAG_BIT])
			begin
				next_s.irq_flag = 1'b0;
			end
			next_s.irq_enable = reg_wdata[WDRCU_IRQ_EN_BIT];
			if (s.win)
			begin
				// Prescale and a clear of reset enable only take effect inside the window
				next_s.prescale = {reg_wdata[WDRCU_PRE_HI_BIT],
					reg_wdata[WDRCU_PRE_LO_MSB:0]};
				next_s.rst_enable = reg_wdata[WDRCU_RST_EN_BIT];
			end
			else if (reg_wdata[WDRCU_RST_EN_BIT])
			begin
				next_s.rst_enable = 1'b1;
			end
			if (open_wr)
			begin
				next_s.win = 1'b1;
				next_s.win_cnt = WDRCU_WIN_W'(WDRCU_WIN_CYCLES - 1);
			end
		end

		// Vector taken clears the flag, and in combined mode the enable
		if (irq_taken)
		begin
			next_s.irq_flag = 1'b0;
			if (wd_mode == WDRCU_MODE_IRQ_RESET)
			begin
				next_s.irq_enable = 1'b0;
			end
		end

		// Hardware set wins over a software or vector clear in the same cycle
		if (set_irq)
		begin
			next_s.irq_flag = 1'b1;
		end

		// Software clears reset causes by writing zero
		if (cause_wr)
		begin
			next_s.usb_flag = s.usb_flag & reg_wdata[WDRCU_USB_BIT];
			next_s.wd_flag = s.wd_flag & reg_wdata[WDRCU_WD_BIT];
			next_s.bo_flag = s.bo_flag & reg_wdata[WDRCU_BO_BIT];
			next_s.ext_flag = s.ext_flag & reg_wdata[WDRCU_EXT_BIT];
			next_s.po_flag = s.po_flag & reg_wdata[WDRCU_PO_BIT];
		end

		// Cause events set their flags, winning over a clear
		if (usb_reset_event)
		begin
			next_s.usb_flag = 1'b1;
		end
		if (fire_rst)
		begin
			next_s.wd_flag = 1'b1;
		end
		if (brownout_event)
		begin
			next_s.bo_flag = 1'b1;
		end
		if (external_reset_event)
		begin
			next_s.ext_flag = 1'b1;
		end

		// A system reset reloads the watchdog controls
		if (any_sysrst)
		begin
			next_s.irq_flag = 1'b0;
			next_s.irq_enable = 1'b0;
			next_s.prescale = '0;
			next_s.win = 1'b0;
			next_s.win_cnt = '0;
			next_s.rst_enable = 1'b0;
			next_s.cnt = '0;
			next_s.div_cnt = '0;
		end

		// Overrides: fuse locks reset mode, cause flag holds enable
		if (wd_always_on_fuse)
		begin
			next_s.rst_enable = 1'b1;
			next_s.irq_enable = 1'b0;
		end
		if (next_s.wd_flag)
		begin
			next_s.rst_enable = 1'b1;
		end

		// Read data stand in the cycle after the strobe only
		next_s.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				WDRCU_CTL_OFFSET:
				begin
					next_s.rdata = {s.irq_flag, s.irq_enable, s.prescale[3],
						s.win, s.rst_enable, s.prescale[2:0]};
				end
				WDRCU_CAUSE_OFFSET:
				begin
					next_s.rdata = {2'h0, s.usb_flag, 1'h0, s.wd_flag,
						s.bo_flag, s.ext_flag, s.po_flag};
				end
				default:
				begin
					next_s.rdata = '0;
				end
			endcase
		end
	end

	// State register; synchronous reset acts as power-on
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			s <= WDRCU_STATE_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs from flip-flops
	assign reg_rdata = s.rdata;
	assign wd_system_reset = s.rst_pulse;

	// Enable is never low while the watchdog cause flag stands
	property p_wde_forced;
		@(posedge clk_sys) disable iff (sys_rst)
		s.wd_flag |-> s.rst_enable;
	endproperty
	a_wde_forced: assert property (p_wde_forced)
		else $error("reset enable low while watchdog cause set");

	// Protected fields hold when written outside the window
	property p_protect;
		@(posedge clk_sys) disable iff (sys_rst)
		(ctl_wr && !s.win && !any_sysrst)
		|=> (s.prescale == $past(s.prescale))
		&& (s.rst_enable || !$past(s.rst_enable));
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected field changed without window");

	// Window opens with a count of three
	property p_window_open;
		@(posedge clk_sys) disable iff (sys_rst)
		(open_wr && !any_sysrst) |=> s.win && (s.win_cnt == 2'h3);
	endproperty
	a_window_open: assert property (p_window_open)
		else $error("change window did not open");

	// Window stays four cycles, then closes
	property p_window_close;
		@(posedge clk_sys) disable iff (sys_rst)
		(open_wr && !any_sysrst) ##1 (!open_wr && !any_sysrst)[*4]
		|=> !s.win;
	endproperty
	a_window_close: assert property (p_window_close)
		else $error("change window not closed after four cycles");

	// Fuse forces reset mode
	property p_fuse_mode;
		@(posedge clk_sys) disable iff (sys_rst)
		wd_always_on_fuse ##1 wd_always_on_fuse
		|-> wd_mode == WDRCU_MODE_RESET;
	endproperty
	a_fuse_mode: assert property (p_fuse_mode)
		else $error("fuse did not force reset mode");

	// Interrupt-mode expiry raises the flag
	property p_irq_set;
		@(posedge clk_sys) disable iff (sys_rst)
		(expire && wd_mode == WDRCU_MODE_IRQ) |=> s.irq_flag;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("interrupt flag not set on expiry");

	// Writing one clears the flag when nothing sets it
	property p_irq_sw_clear;
		@(posedge clk_sys) disable iff (sys_rst)
		(ctl_wr && reg_wdata[WDRCU_IRQ_FLAG_BIT] && !set_irq)
		|=> !s.irq_flag;
	endproperty
	a_irq_sw_clear: assert property (p_irq_sw_clear)
		else $error("interrupt flag not cleared by write of one");

	// No request without core enable
	property p_irq_gate;
		@(posedge clk_sys) disable iff (sys_rst)
		(!core_global_irq_enable || !s.irq_flag) |-> !wd_irq_req;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt request without enable");

	// Combined mode vector drops to plain reset mode
	property p_combined_ack;
		@(posedge clk_sys) disable iff (sys_rst)
		(irq_taken && wd_mode == WDRCU_MODE_IRQ_RESET && !ctl_wr)
		|=> !s.irq_enable && !s.irq_flag;
	endproperty
	a_combined_ack: assert property (p_combined_ack)
		else $error("combined-mode vector did not clear enable");

	// Unserviced flag at expiry gives a reset pulse and cause flag
	property p_escalate;
		@(posedge clk_sys) disable iff (sys_rst)
		(expire && wd_mode == WDRCU_MODE_IRQ_RESET && s.irq_flag)
		|=> wd_system_reset && s.wd_flag ##1 !wd_system_reset;
	endproperty
	a_escalate: assert property (p_escalate)
		else $error("no reset on unserviced combined interrupt");

	// Reserved cause bits read zero
	property p_cause_reserved;
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd && reg_addr == WDRCU_CAUSE_OFFSET)
		|=> (reg_rdata[7:6] == 2'h0) && !reg_rdata[4];
	endproperty
	a_cause_reserved: assert property (p_cause_reserved)
		else $error("reserved cause bit read nonzero");

	// Power-on flag only falls by a write of zero
	property p_po_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		(s.po_flag && !(cause_wr && !reg_wdata[WDRCU_PO_BIT]))
		|=> s.po_flag;
	endproperty
	a_po_hold: assert property (p_po_hold)
		else $error("power-on flag lost without write");

	// Restart zeroes the counter and keeps settings
	property p_restart;
		@(posedge clk_sys) disable iff (sys_rst)
		(wd_restart && !reg_wr && !any_sysrst)
		|=> (s.cnt == '0) && (s.prescale == $past(s.prescale));
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart did not clear counter");

endmodule

// file: hdl/wdrcu_pkg.sv
// Constants, types and state layout of the watchdog and reset-cause unit
package wdrcu_pkg;

	// Register bus geometry
	localparam int unsigned WDRCU_ADDR_W = 8;
	localparam int unsigned WDRCU_DATA_W = 8;

	// Register offsets
	localparam logic [7:0] WDRCU_CTL_OFFSET = 8'h60;
	localparam logic [7:0] WDRCU_CAUSE_OFFSET = 8'h54;

	// Control and status field positions
	localparam int unsigned WDRCU_IRQ_FLAG_BIT = 7;
	localparam int unsigned WDRCU_IRQ_EN_BIT = 6;
	localparam int unsigned WDRCU_PRE_HI_BIT = 5;
	localparam int unsigned WDRCU_WIN_BIT = 4;
	localparam int unsigned WDRCU_RST_EN_BIT = 3;
	localparam int unsigned WDRCU_PRE_LO_MSB = 2;

	// Reset-cause field positions
	localparam int unsigned WDRCU_USB_BIT = 5;
	localparam int unsigned WDRCU_WD_BIT = 3;
	localparam int unsigned WDRCU_BO_BIT = 2;
	localparam int unsigned WDRCU_EXT_BIT = 1;
	localparam int unsigned WDRCU_PO_BIT = 0;

	// Timing: change window length in system clock cycles
	localparam int unsigned WDRCU_WIN_CYCLES = 4;
	localparam int unsigned WDRCU_WIN_W = 2;

	// Timing: slow oscillator derived from the system clock
	localparam int unsigned WDRCU_CLK_HZ = 200_000_000;
	localparam int unsigned WDRCU_OSC_HZ = 128_000;
	localparam int unsigned WDRCU_DIV_CYCLES = WDRCU_CLK_HZ / WDRCU_OSC_HZ;
	localparam int unsigned WDRCU_DIV_W = 16;

	// Time-out: single period is base shifted left by the prescale code
	localparam int unsigned WDRCU_BASE_TIMEOUT = 2048;
	localparam logic [3:0] WDRCU_PRE_MAX_CODE = 4'h9;
	localparam int unsigned WDRCU_CNT_W = 22;

	// Operating mode, coded as {reset enable, interrupt enable}
	typedef enum logic [1:0] {
		WDRCU_MODE_STOPPED = 2'b00,
		WDRCU_MODE_IRQ = 2'b01,
		WDRCU_MODE_RESET = 2'b10,
		WDRCU_MODE_IRQ_RESET = 2'b11
	} wdrcu_mode_type;

	// Complete state of the unit
	typedef struct packed {
		logic irq_flag;
		logic irq_enable;
		logic [3:0] prescale;
		logic win;
		logic [WDRCU_WIN_W-1:0] win_cnt;
		logic rst_enable;
		logic [WDRCU_CNT_W-1:0] cnt;
		logic [WDRCU_DIV_W-1:0] div_cnt;
		logic usb_flag;
		logic wd_flag;
		logic bo_flag;
		logic ext_flag;
		logic po_flag;
		logic [WDRCU_DATA_W-1:0] rdata;
		logic rst_pulse;
	} wdrcu_state_type;

	// Power-on value: only the power-on cause is set
	localparam wdrcu_state_type WDRCU_STATE_RESET = '{
		po_flag: 1'h1,
		default: '0
	};

endpackage

// file: dv/wdrcu_core_model.sv
// Processor core model: register master, restart and vector taking
`timescale 1ns/1ps
module wdrcu_core_model
	import wdrcu_pkg::*;
(
	input wire logic clk_sys,
	output logic [WDRCU_ADDR_W-1:0] reg_addr,
	output logic [WDRCU_DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [WDRCU_DATA_W-1:0] reg_rdata,
	output logic core_global_irq_enable,
	output logic wd_restart,
	output logic wd_irq_ack,
	input wire logic wd_irq_req
);
	bit auto_ack = 1'b1;
	int ack_delay = 0;

	// Idle bus and core lines at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		core_global_irq_enable = 1'b1;
		wd_restart = 1'b0;
		wd_irq_ack = 1'b0;
	end

	// One-cycle write; data turned over once the strobe drops
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// One-cycle read; data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Restart instruction as a one-cycle pulse
	task automatic restart();
		@(posedge clk_sys);
		wd_restart <= 1'b1;
		@(posedge clk_sys);
		wd_restart <= 1'b0;
	endtask

	// Global interrupt enable of the core, changed right after an edge
	task automatic set_gie(input logic v);
		@(posedge clk_sys);
		core_global_irq_enable <= v;
	endtask

	// Take the vector, promptly or after a delay
	always @(posedge clk_sys)
	begin
		if (auto_ack && wd_irq_req === 1'b1 && !wd_irq_ack)
		begin
			repeat (ack_delay) @(posedge clk_sys);
			wd_irq_ack <= 1'b1;
			@(posedge clk_sys);
			wd_irq_ack <= 1'b0;
		end
	end
endmodule

// file: dv/wdrcu_top_tb.sv
// Self-checking bench for the watchdog and reset-cause unit
`timescale 1ns/1ps
module wdrcu_top_tb;
	import wdrcu_pkg::*;
	localparam logic [7:0] CTL = WDRCU_CTL_OFFSET;
	localparam logic [7:0] CS = WDRCU_CAUSE_OFFSET;
	logic clk_sys = 1'b0;
	logic sys_rst, fuse, ev_ext, ev_bo, ev_usb;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, gie, restart, ack, req, wdrst;
	int n_rst = 0;
	int n_req = 0;
	int base_rst = 0;
	int base_req = 0;
	int fail_count = 0;
	int num_checks = 0;

	// Unit with short counts: single time-out 2 ticks, tick every 2 clocks
	wdrcu_top #(.BASE_TIMEOUT(2), .DIV_CYCLES(2)) dut_u (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.wd_always_on_fuse(fuse), .core_global_irq_enable(gie),
		.wd_restart(restart), .wd_irq_ack(ack), .wd_irq_req(req),
		.wd_system_reset(wdrst), .external_reset_event(ev_ext),
		.brownout_event(ev_bo), .usb_reset_event(ev_usb));

	// Core on the far side
	wdrcu_core_model core_u (
		.clk_sys(clk_sys), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.core_global_irq_enable(gie), .wd_restart(restart),
		.wd_irq_ack(ack), .wd_irq_req(req));

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	// Count cycles with a request or a reset showing
	always @(posedge clk_sys)
	begin
		if (wdrst === 1'b1) n_rst <= n_rst + 1;
		if (req === 1'b1) n_req <= n_req + 1;
	end

	task automatic end_sim();
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int n, input int lo, input int hi);
		num_checks++;
		if (n < lo || n > hi)
		begin
			fail_count++;
			$display("[FAIL] %0t wait of %0d cycles", $time, n);
		end
	endtask

	// Start of a span in which no request and no reset may show
	task automatic mark_quiet();
		base_rst = n_rst;
		base_req = n_req;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		core_u.rd(a, d);
		chk8(d, e);
	endtask

	// Cycles from now until request (0) or system reset (1) shows
	task automatic wait_hi(input bit s, input int lo, input int hi);
		int n;
		n = 0;
		while (n <= hi && ((s ? wdrst : req) !== 1'b1))
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk_rng(n, lo, hi);
	endtask

	// Stop the watchdog the safe way
	task automatic clr_wd();
		core_u.restart();
		core_u.wr(CS, 8'h00);
		core_u.wr(CTL, 8'h18);
		core_u.wr(CTL, 8'h00);
		repeat (2) @(posedge clk_sys);
		rc(CTL, 8'h00);
	endtask

	task automatic t_reset();
		rc(CS, 8'h01);
		rc(CTL, 8'h00);
		rc(8'h10, 8'h00);
		mark_quiet();
		repeat (40) @(posedge clk_sys);
		chk8({6'h00, n_req != base_req, n_rst != base_rst}, 8'h00);
	endtask

	task automatic t_cause();
		@(posedge clk_sys);
		{ev_usb, ev_bo, ev_ext} <= 3'b111;
		@(posedge clk_sys);
		{ev_usb, ev_bo, ev_ext} <= 3'b000;
		rc(CS, 8'h27);
		core_u.wr(CS, 8'hff);
		rc(CS, 8'h27);
		core_u.wr(CS, 8'hde);
		rc(CS, 8'h06);
		core_u.wr(CS, 8'h00);
		rc(CS, 8'h00);
	endtask

	// Window bit still reads high two cycles after an in-window write
	task automatic t_window();
		core_u.wr(CTL, 8'h18);
		core_u.wr(CTL, 8'h29);
		rc(CTL, 8'h39);
		core_u.wr(CTL, 8'h02);
		rc(CTL, 8'h29);
		core_u.wr(CTL, 8'h18);
		rc(CTL, 8'h39);
		@(posedge clk_sys);
		core_u.wr(CTL, 8'h02);
		rc(CTL, 8'h29);
		core_u.wr(CTL, 8'h18);
		core_u.wr(CTL, 8'h21);
		rc(CTL, 8'h31);
	endtask

	task automatic t_irq();
		core_u.wr(CTL, 8'h18);
		core_u.wr(CTL, 8'h42);
		core_u.set_gie(1'b0);
		core_u.ack_delay = 2;
		mark_quiet();
		core_u.restart();
		repeat (36) @(posedge clk_sys);
		chk8({6'h00, n_req != base_req, n_rst != base_rst}, 8'h00);
		rc(CTL, 8'hc2);
		core_u.wr(CTL, 8'hc2);
		rc(CTL, 8'h42);
		core_u.set_gie(1'b1);
		core_u.restart();
		wait_hi(0, 31, 36);
		repeat (5) @(posedge clk_sys);
		#1;
		chk8({7'h00, req}, 8'h00);
		rc(CTL, 8'h42);
		core_u.ack_delay = 0;
		clr_wd();
	endtask

	task automatic t_reset_mode();
		core_u.wr(CTL, 8'h18);
		core_u.wr(CTL, 8'h09);
		core_u.restart();
		wait_hi(1, 15, 20);
		rc(CS, 8'h08);
		rc(CTL, 8'h08);
		clr_wd();
	endtask

	task automatic t_combined();
		core_u.wr(CTL, 8'h48);
		core_u.restart();
		wait_hi(0, 7, 12);
		core_u.restart();
		rc(CTL, 8'h08);
		core_u.wr(CTL, 8'h48);
		core_u.auto_ack = 1'b0;
		core_u.restart();
		wait_hi(0, 7, 12);
		wait_hi(1, 6, 12);
		rc(CS, 8'h08);
		core_u.restart();
		core_u.wr(CTL, 8'h18);
		core_u.wr(CTL, 8'h00);
		repeat (2) @(posedge clk_sys);
		rc(CTL, 8'h08);
		core_u.auto_ack = 1'b1;
		clr_wd();
	endtask

	task automatic t_restart();
		core_u.wr(CTL, 8'h08);
		mark_quiet();
		repeat (8)
		begin
			core_u.restart();
			repeat (3) @(posedge clk_sys);
		end
		chk8({6'h00, n_req != base_req, n_rst != base_rst}, 8'h00);
		rc(CTL, 8'h08);
		clr_wd();
	endtask

	task automatic t_fuse();
		@(posedge clk_sys);
		fuse <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rc(CTL, 8'h08);
		core_u.wr(CTL, 8'h40);
		rc(CTL, 8'h08);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		fuse <= 1'b0;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rc(CS, 8'h01);
		rc(CTL, 8'h00);
	endtask

	// Main sequence
	initial
	begin
		sys_rst = 1'b1;
		fuse = 1'b0;
		{ev_usb, ev_bo, ev_ext} = 3'b000;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_cause();
		t_window();
		t_irq();
		t_reset_mode();
		t_combined();
		t_restart();
		t_fuse();
		end_sim();
	end

	// Cut a hang short
	initial
	begin
		#100000;
		fail_count++;
		end_sim();
	end
endmodule
